// File: hdl/fst_flame_supervisor.sv
// Flame supervisor: safety time, switch bank check, flame-on and slave address.
// Assumes switch, flame and range inputs are pins; sample, threshold and
// request inputs come from logic on i_clk.
`default_nettype none
module fst_flame_supervisor
  import fst_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DEF,
  parameter int unsigned INT_W = INT_W_DEF,
  parameter int unsigned WIN_LEN = WIN_LEN_DEF
)
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic [MODE_SW_W-1:0] i_mode_switch_bank_first,
  input wire logic [MODE_SW_W-1:0] i_mode_switch_bank_second,
  input wire logic [ADDR_SW_W-1:0] i_slave_address_switch,
  input wire logic i_flame_digital,
  input wire logic i_range_select,
  input wire logic [INT_W-1:0] i_threshold_a,
  input wire logic [INT_W-1:0] i_threshold_b,
  input wire logic i_sample_valid,
  input wire logic signed [SAMPLE_W-1:0] i_ac_sample,
  input wire logic [GAIN_W-1:0] i_gain,
  input wire logic i_req_valid,
  input wire logic [REQ_ADDR_W-1:0] i_req_address,
  output logic o_flame_relay,
  output logic o_flame_on,
  output logic o_switch_error,
  output logic o_error_shutdown,
  output logic o_range_b,
  output logic [INT_W-1:0] o_intensity,
  output logic [ADDR_W-1:0] o_slave_address,
  output logic o_req_accept
);
  localparam int unsigned PIN_W = 2 * MODE_SW_W + ADDR_SW_W + 2;
  localparam int unsigned PRE_W = $clog2(MS_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CYCLES - 1);

  logic [PIN_W-1:0] pin_s1, pin_s2;
  logic [MODE_SW_W-1:0] bank1_s, bank2_s;
  logic [ADDR_SW_W-1:0] addr_sw_s;
  logic flame_s, range_s;
  logic [PRE_W-1:0] pre_cnt, next_pre_cnt;
  logic tick;
  fst_relay_t state, next_state;
  logic [MS_W-1:0] hold_cnt, next_hold_cnt, mism_cnt, next_mism_cnt, safety_ms;
  logic mismatch, flame_ok, flame_on, next_flame_on, shutdown;
  logic [INT_W-1:0] active_thr;
  logic [ADDR_W-1:0] own_addr, next_own_addr;
  logic accept, next_accept, switch_err;

  fst_meas_if #(.INT_W(INT_W)) meas ();

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end
    else if (i_ce)
    begin
      pin_s1 <= {i_mode_switch_bank_first, i_mode_switch_bank_second,
                 i_slave_address_switch, i_flame_digital, i_range_select};
      pin_s2 <= pin_s1;
    end
  end

  assign {bank1_s, bank2_s, addr_sw_s, flame_s, range_s} = pin_s2;

  // ==========================================================
  // Intensity path
  assign meas.sample_valid = i_sample_valid;
  assign meas.ac_sample = i_ac_sample;
  assign meas.gain = i_gain;

  fst_intensity_integ #(.INT_W(INT_W), .WIN_LEN(WIN_LEN)) u_integ
  (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .meas(meas)
  );

  // ==========================================================
  // Decode and millisecond tick
  always_comb
  begin
    safety_ms = fst_safety_ms(bank1_s[1:0]);
    active_thr = range_s ? i_threshold_b : i_threshold_a;
    flame_ok = flame_s && (meas.intensity > active_thr);
    mismatch = (bank1_s != bank2_s);
    tick = i_ce && (pre_cnt == PRE_LAST);
    next_pre_cnt = (pre_cnt == PRE_LAST) ? '0 : pre_cnt + PRE_W'(1);
  end

  // ==========================================================
  // Switch bank comparison
  always_comb
  begin
    next_mism_cnt = mism_cnt;
    if (!mismatch)
      next_mism_cnt = '0;
    else if (tick && mism_cnt != MISMATCH_MS)
      next_mism_cnt = mism_cnt + MS_W'(1);
  end

  // ==========================================================
  // Relay control
  always_comb
  begin
    next_state = state;
    next_hold_cnt = hold_cnt;
    case (state)
      FST_OPEN:
        if (flame_ok)
          next_state = FST_CLOSED;
      FST_CLOSED:
        if (!flame_ok)
        begin
          next_state = FST_HOLD;
          next_hold_cnt = safety_ms;
        end
      FST_HOLD:
        if (flame_ok)
          next_state = FST_CLOSED;
        else if (tick)
        begin
          if (hold_cnt <= MS_W'(1))
            next_state = FST_OPEN;
          else
            next_hold_cnt = hold_cnt - MS_W'(1);
        end
      FST_SHUT:
        next_state = FST_SHUT;
      default:
        next_state = FST_OPEN;
    endcase
    if (mism_cnt == MISMATCH_MS)
      next_state = FST_SHUT;
    next_flame_on = flame_ok && (next_state != FST_SHUT);
    next_own_addr = ADDR_W'({1'b0, addr_sw_s}) + ADDR_BASE;
    next_accept = i_req_valid && (i_req_address == {1'b0, own_addr});
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pre_cnt <= '0;
      mism_cnt <= '0;
      state <= FST_OPEN;
      hold_cnt <= '0;
      flame_on <= 1'b0;
      own_addr <= ADDR_BASE;
      accept <= 1'b0;
      switch_err <= 1'b0;
    end
    else if (i_ce)
    begin
      pre_cnt <= next_pre_cnt;
      mism_cnt <= next_mism_cnt;
      state <= next_state;
      hold_cnt <= next_hold_cnt;
      flame_on <= next_flame_on;
      own_addr <= next_own_addr;
      accept <= next_accept;
      switch_err <= mismatch;
    end
  end

  assign shutdown = (state == FST_SHUT);
  assign o_flame_relay = (state == FST_CLOSED) || (state == FST_HOLD);
  assign o_flame_on = flame_on;
  assign o_switch_error = switch_err;
  assign o_error_shutdown = shutdown;
  assign o_range_b = range_s;
  assign o_intensity = meas.intensity;
  assign o_slave_address = own_addr;
  assign o_req_accept = accept;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  chk_safety_decode: assert property ((bank1_s[1:0] == 2'h3) |-> safety_ms == 13'h1388)
    else $error("on/on positions must give 5 s");
  chk_default_time: assert property ((bank1_s[1:0] == 2'h0) |-> safety_ms == 13'h03E8)
    else $error("off/off positions must give 1 s");
  chk_hold_start: assert property (
    i_ce && state == FST_CLOSED && !flame_ok && mism_cnt != MISMATCH_MS
    |=> state == FST_HOLD && hold_cnt == $past(safety_ms) && o_flame_relay)
    else $error("flame loss did not start the countdown");
  chk_hold_expire: assert property (
    i_ce && state == FST_HOLD && !flame_ok && tick && hold_cnt == 13'h0001
    && mism_cnt != MISMATCH_MS |=> !o_flame_relay)
    else $error("relay still closed after expiry");
  chk_hold_restart: assert property (
    i_ce && state == FST_HOLD && flame_ok && mism_cnt != MISMATCH_MS |=> state == FST_CLOSED)
    else $error("returning flame did not restart");
  chk_mismatch_shut: assert property (
    i_ce && mism_cnt == MISMATCH_MS |=> o_error_shutdown ##1 o_error_shutdown && !o_flame_relay)
    else $error("mismatch timeout did not shut down");
  chk_agree_clear: assert property (i_ce && !mismatch |=> mism_cnt == '0)
    else $error("agreement did not clear the mismatch timer");
  chk_flame_on: assert property (
    i_ce && flame_s && meas.intensity > active_thr && mism_cnt != MISMATCH_MS
    && state != FST_SHUT |=> o_flame_on)
    else $error("flame-on missed above threshold");
  chk_addr_filter: assert property (
    i_ce && i_req_address != {1'b0, own_addr} |=> !o_req_accept)
    else $error("request for another address accepted");
  chk_addr_range: assert property (own_addr >= ADDR_BASE && own_addr <= ADDR_MAX)
    else $error("slave address out of 1..64");
  chk_range_fallback: assert property (
    i_ce && !range_s && state == FST_OPEN && meas.intensity <= i_threshold_a
    |=> !o_flame_relay)
    else $error("idle range line must select the primary range");
endmodule
`default_nettype wire

// File: hdl/fst_intensity_integ.sv
// Integrates the gained alternating flame component over a sample window.
// Assumes samples already stripped of their DC part, on the same clock.
`default_nettype none
module fst_intensity_integ
  import fst_pkg::*;
#(
  parameter int unsigned INT_W = INT_W_DEF,
  parameter int unsigned WIN_LEN = WIN_LEN_DEF
)
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  fst_meas_if.integ meas
);
  localparam int unsigned CW = $clog2(WIN_LEN);
  localparam logic [CW-1:0] LAST_IDX = CW'(WIN_LEN - 1);
  logic [INT_W-1:0] acc, next_acc, result, next_result;
  logic [CW-1:0] cnt, next_cnt;
  logic [SAMPLE_W-1:0] mag;
  logic [TERM_W-1:0] term;
  logic last;

  // ==========================================================
  // Window accumulation
  // gained AC integration
  always_comb
  begin
    mag = meas.ac_sample[SAMPLE_W-1] ? SAMPLE_W'(-meas.ac_sample) : SAMPLE_W'(meas.ac_sample);
    term = {4'h0, mag} * {12'h000, meas.gain};
    last = (cnt == LAST_IDX);
    next_acc = acc;
    next_cnt = cnt;
    next_result = result;
    if (meas.sample_valid)
    begin
      if (last)
      begin
        next_result = acc + INT_W'(term);
        next_acc = '0;
        next_cnt = '0;
      end
      else
      begin
        next_acc = acc + INT_W'(term);
        next_cnt = cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      acc <= '0;
      cnt <= '0;
      result <= '0;
    end
    else if (i_ce)
    begin
      acc <= next_acc;
      cnt <= next_cnt;
      result <= next_result;
    end
  end

  assign meas.intensity = result;

  // ==========================================================
  // Checks
  chk_integrate_step: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    i_ce && meas.sample_valid && !last |=> acc == $past(acc) + INT_W'($past(term)))
    else $error("integrator did not add the gained sample");
  chk_window_result: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    i_ce && meas.sample_valid && last |=> result == $past(acc) + INT_W'($past(term)) && acc == '0)
    else $error("window result not published");
endmodule
`default_nettype wire

// File: hdl/fst_meas_if.sv
// Measurement path between the supervisor and the intensity integrator.
// Assumes both ends share one clock.
`default_nettype none
interface fst_meas_if
  import fst_pkg::*;
#(
  parameter int unsigned INT_W = INT_W_DEF
);
  logic sample_valid;
  logic signed [SAMPLE_W-1:0] ac_sample;
  logic [GAIN_W-1:0] gain;
  logic [INT_W-1:0] intensity;
  modport src (output sample_valid, output ac_sample, output gain, input intensity);
  modport integ (input sample_valid, input ac_sample, input gain, output intensity);
endinterface
`default_nettype wire

// File: hdl/fst_pkg.sv
// Constants shared by the flame safety supervisor and its integrator.
// Assumes a single 100 MHz clock domain.
`default_nettype none
package fst_pkg;
  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
  localparam int unsigned MS_W = 13;
  localparam int unsigned SAFETY_T1_S = 1;
  localparam int unsigned SAFETY_T2_S = 2;
  localparam int unsigned SAFETY_T3_S = 3;
  localparam int unsigned SAFETY_T5_S = 5;
  localparam int unsigned MISMATCH_S = 8;
  localparam logic [MS_W-1:0] MISMATCH_MS = MS_W'(MISMATCH_S * MS_PER_S);
  // ==========================================================
  // Switch and data widths
  localparam int unsigned MODE_SW_W = 8;
  localparam int unsigned ADDR_SW_W = 6;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned REQ_ADDR_W = 8;
  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned GAIN_W = 4;
  localparam int unsigned TERM_W = 16;
  localparam int unsigned INT_W_DEF = 24;
  localparam int unsigned WIN_LEN_DEF = 16;
  localparam logic [ADDR_W-1:0] ADDR_BASE = 7'h01;
  localparam logic [ADDR_W-1:0] ADDR_MAX = 7'h40;
  // ==========================================================
  // Relay state, Gray along open-closed-hold
  typedef enum logic [1:0]
  {
    FST_OPEN = 2'h0,
    FST_CLOSED = 2'h1,
    FST_HOLD = 2'h3,
    FST_SHUT = 2'h2
  } fst_relay_t;

  // Safety time in ms from mode switch positions 1 and 2
  function automatic logic [MS_W-1:0] fst_safety_ms(input logic [1:0] sel);
    case (sel)
      2'h1: fst_safety_ms = MS_W'(SAFETY_T2_S * MS_PER_S);
      2'h2: fst_safety_ms = MS_W'(SAFETY_T3_S * MS_PER_S);
      2'h3: fst_safety_ms = MS_W'(SAFETY_T5_S * MS_PER_S);
      default: fst_safety_ms = MS_W'(SAFETY_T1_S * MS_PER_S);
    endcase
  endfunction
endpackage
`default_nettype wire

// File: verif/flame_safety_timer_config_tb.sv
// Testbench of the flame supervisor: address, range, intensity, relay, banks.
// Assumes the design package and master model are compiled first.
`default_nettype none
module flame_safety_timer_config_tb
  import fst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MSC = 2;
  localparam int LIMIT = 90000;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] bank1 = 8'h00;
  logic [7:0] bank2 = 8'h00;
  logic [5:0] addr_sw = 6'h00;
  logic flame = 1'b0;
  logic range_sel = 1'b0;
  logic [23:0] thr_a = 24'h000000;
  logic [23:0] thr_b = 24'h000000;
  logic sv = 1'b0;
  logic signed [11:0] smp = 12'h000;
  logic [3:0] gain = 4'h0;
  logic go = 1'b0;
  logic [7:0] maddr = 8'h00;
  logic rv;
  logic [7:0] ra;
  logic relay, fon, serr, shut, rb, acc;
  logic [23:0] inten;
  logic [6:0] saddr;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  fst_master_model u_master (.i_clk(clk), .i_go(go), .i_addr(maddr),
    .o_req_valid(rv), .o_req_address(ra));
  fst_flame_supervisor #(.MS_CYCLES(MSC)) u_dut (.i_clk(clk), .i_nrst(nrst), .i_ce(1'b1),
    .i_mode_switch_bank_first(bank1), .i_mode_switch_bank_second(bank2),
    .i_slave_address_switch(addr_sw), .i_flame_digital(flame), .i_range_select(range_sel),
    .i_threshold_a(thr_a), .i_threshold_b(thr_b), .i_sample_valid(sv), .i_ac_sample(smp),
    .i_gain(gain), .i_req_valid(rv), .i_req_address(ra), .o_flame_relay(relay),
    .o_flame_on(fon), .o_switch_error(serr), .o_error_shutdown(shut), .o_range_b(rb),
    .o_intensity(inten), .o_slave_address(saddr), .o_req_accept(acc));
  // ==========================================================
  // Helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic req(input logic [7:0] a, input logic exp);
    @(posedge clk);
    go <= 1'b1;
    maddr <= a;
    @(posedge clk);
    go <= 1'b0;
    step(1);
    chk("req_accept", 32'(acc), 32'(exp));
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_addr();
    chk("addr_default", 32'(saddr), 32'h1);
    req(8'h01, 1'b1);
    @(posedge clk) addr_sw <= 6'h3F;
    step(5);
    chk("addr_max", 32'(saddr), 32'h40);
    req(8'h40, 1'b1);
    req(8'h05, 1'b0);
    @(posedge clk) addr_sw <= 6'h00;
    $display("test address done");
  endtask
  task automatic t_range();
    @(posedge clk) range_sel <= 1'b1;
    step(4);
    chk("range_b", 32'(rb), 32'h1);
    @(posedge clk) range_sel <= 1'b0;
    step(4);
    chk("range_a", 32'(rb), 32'h0);
    $display("test range done");
  endtask
  task automatic t_integ();
    @(posedge clk);
    gain <= 4'h3;
    smp <= -12'sh064;
    repeat (16)
    begin
      @(posedge clk) sv <= 1'b1;
    end
    @(posedge clk) sv <= 1'b0;
    step(3);
    chk("intensity", 32'(inten), 32'h000012C0);
    $display("test intensity done");
  endtask
  task automatic t_flame();
    @(posedge clk);
    thr_a <= 24'h0012C0;
    flame <= 1'b1;
    step(6);
    chk("flame_on_equal", 32'(fon), 32'h0);
    @(posedge clk) range_sel <= 1'b1;
    step(6);
    chk("flame_on_b", 32'(fon), 32'h1);
    chk("relay_b", 32'(relay), 32'h1);
    @(posedge clk);
    range_sel <= 1'b0;
    thr_a <= 24'h000000;
    $display("test flame done");
  endtask
  task automatic t_safety();
    int ms[4];
    ms = '{SAFETY_T1_S * 1000, SAFETY_T2_S * 1000, SAFETY_T3_S * 1000, SAFETY_T5_S * 1000};
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk);
      bank1 <= 8'(c);
      bank2 <= 8'(c);
      step(6);
      @(posedge clk) flame <= 1'b0;
      step(ms[c] * MSC / 2);
      @(posedge clk) flame <= 1'b1;
      step(ms[c] * MSC / 2 + 20);
      chk("relay_restart", 32'(relay), 32'h1);
      @(posedge clk) flame <= 1'b0;
      step((ms[c] - 1) * MSC);
      chk("relay_before", 32'(relay), 32'h1);
      step(MSC + 6);
      chk("relay_after", 32'(relay), 32'h0);
      @(posedge clk) flame <= 1'b1;
      step(6);
    end
    $display("test safety done");
  endtask
  task automatic t_banks();
    @(posedge clk) bank2 <= 8'h07;
    step(5);
    chk("switch_error", 32'(serr), 32'h1);
    step(8000 * MSC - 40);
    @(posedge clk) bank2 <= bank1;
    step(5);
    chk("switch_clear", 32'(serr), 32'h0);
    step(100);
    chk("no_shutdown", 32'(shut), 32'h0);
    @(posedge clk) bank2 <= 8'h07;
    step(8000 * MSC - 10);
    chk("shutdown_early", 32'(shut), 32'h0);
    step(20);
    chk("shutdown", 32'(shut), 32'h1);
    chk("relay_shut", 32'(relay), 32'h0);
    chk("flame_on_shut", 32'(fon), 32'h0);
    $display("test banks done");
  endtask
  // ==========================================================
  // Timeout and main sequence
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      err_total++;
      test_done();
    end
  end
  initial
  begin
    step(16);
    chk("reset_relay", 32'(relay), 32'h0);
    @(posedge clk) nrst <= 1'b1;
    step(4);
    t_addr();
    t_range();
    t_integ();
    t_flame();
    t_safety();
    t_banks();
    test_done();
  end
endmodule
`default_nettype wire

// File: verif/fst_master_model.sv
// Bus master model: issues one decoded request per go pulse.
// Assumes the testbench drives i_go and i_addr on the rising edge.
`default_nettype none
module fst_master_model
  import fst_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [REQ_ADDR_W-1:0] i_addr,
  output logic o_req_valid,
  output logic [REQ_ADDR_W-1:0] o_req_address
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Request pulse
  // master addresses node
  always_ff @(posedge i_clk)
  begin
    o_req_valid <= i_go;
    o_req_address <= i_go ? i_addr : ~o_req_address;
  end
endmodule
`default_nettype wire
